// [include/otpc_pkg.sv]
// Package of register map, fields, codes and timing for the OTP controller
package otpc_pkg;
  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [7:0] ADDR_FAULT         = 8'h00;
  localparam logic [7:0] ADDR_PAGE_ONE      = 8'h04;
  localparam logic [7:0] ADDR_PAGE_TWO      = 8'h08;
  localparam logic [7:0] ADDR_SEC_BLK       = 8'h0C;
  localparam logic [7:0] ADDR_DED_BLK       = 8'h10;
  localparam logic [7:0] ADDR_PROG_STAT     = 8'h14;
  localparam logic [7:0] ADDR_PROG_CTRL     = 8'h18;
  localparam logic [7:0] ADDR_UNLOCK_FIRST  = 8'h20;
  localparam logic [7:0] ADDR_UNLOCK_SECOND = 8'h30;
  localparam logic [7:0] ADDR_CUST_SHADOW   = 8'h40;
  localparam logic [7:0] ADDR_FAULT_CLR     = 8'h1C;

  // ********************************************************
  // Unlock sequence and program codes
  // ********************************************************
  localparam logic [7:0] UNLOCK_1A = 8'h02;
  localparam logic [7:0] UNLOCK_1B = 8'hB7;
  localparam logic [7:0] UNLOCK_1C = 8'h78;
  localparam logic [7:0] UNLOCK_1D = 8'hBC;
  localparam logic [7:0] UNLOCK_2A = 8'h7E;
  localparam logic [7:0] UNLOCK_2B = 8'h12;
  localparam logic [7:0] UNLOCK_2C = 8'h08;
  localparam logic [7:0] UNLOCK_2D = 8'h6F;
  localparam logic [1:0] GO_PAGE_ONE = 2'h1;
  localparam logic [1:0] GO_PAGE_TWO = 2'h3;
  localparam logic [3:0] UNLOCK_DONE = 4'h8;

  // ********************************************************
  // Geometry and timing
  // ********************************************************
  localparam int NUM_BLOCKS  = 4;
  localparam int BLK_BITS    = 2;
  localparam int CODE_BITS   = 13;
  localparam int FACT_BASE   = 0;
  localparam int PAGE1_BASE  = 4;
  localparam int PAGE2_BASE  = 8;
  localparam int CRC_ADDR    = 12;
  localparam int T_PROG_US   = 100;
  localparam int T_STAB_US   = 1;
  localparam int CLK_MHZ     = 200;
  localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
  localparam int STAB_CYCLES = T_STAB_US * CLK_MHZ;
  localparam logic [7:0] HW_DEFAULT = 8'h00;

  // ********************************************************
  // Page status bit positions
  // ********************************************************
  localparam int PS_LOADED = 0;
  localparam int PS_LOAD_WARNING = 1;
  localparam int PS_LOAD_ERROR = 2;
  localparam int PS_FORMAT_ERROR = 3;
  localparam int PS_PROGRAMMED_OK = 4;
  localparam int PS_TRY = 5;
  localparam int PS_OVERVOLT_OK = 6;
  localparam int PS_UNDERVOLT_OK = 7;

  typedef struct packed {
    logic global_overvolt_err;
    logic customer_crc_err;
    logic factory_crc_err;
    logic customer_load_err;
    logic factory_load_err;
    logic double_err_flag;
    logic single_err_flag;
  } otpc_fault_t;

  typedef struct packed {
    logic unlocked;
    logic stab_err;
    logic overvolt_err;
    logic program_page_err;
    logic done;
  } otpc_pstat_t;

  typedef enum logic [2:0] {
    ST_LOAD   = 3'h0,
    ST_CRC    = 3'h1,
    ST_IDLE   = 3'h2,
    ST_STAB   = 3'h3,
    ST_PROG   = 3'h4,
    ST_STATUS = 3'h5
  } otpc_state_t;
endpackage

// [logic/otpc_ctrl.sv]
// OTP page load, ECC/CRC checking and customer page programming controller
`timescale 1ns/1ps
module otpc_ctrl #(
  parameter int PROG_CYCLES = otpc_pkg::PROG_CYCLES
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic [12:0]      o_otp_addr,
  input  wire logic [12:0] i_otp_rdata,
  output logic             o_otp_we,
  output logic [12:0]      o_otp_wdata,
  input  wire logic        i_vpp_ov,
  input  wire logic        i_vpp_uv,
  output logic [31:0]      o_cust_cfg,
  output logic             o_load_done
);
  // ********************************************************
  // Hamming(12,8) plus overall parity: decode and encode
  // ********************************************************
  function automatic logic [11:0] otpc_dec(input logic [12:0] cw);
    logic [3:0] syn;
    logic       par;
    logic [12:0] fx;
    syn = '0;
    for (int i = 1; i <= 12; i++) begin
      if (cw[i]) begin
        syn = syn ^ 4'(i);
      end
    end
    par = ^cw;
    fx = cw;
    if (par && syn <= 4'hC) begin
      fx[syn] = ~fx[syn];
    end
    // Result: {single, double, 2'b0, data}
    otpc_dec = {par, (!par && syn != 4'h0), 2'h0,
                fx[12], fx[11], fx[10], fx[9], fx[7], fx[6], fx[5], fx[3]};
  endfunction

  function automatic logic [12:0] otpc_enc(input logic [7:0] d);
    logic [12:0] c;
    c = '0;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
    c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
    c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
    c[0] = ^c[12:1];
    otpc_enc = c;
  endfunction

  function automatic logic [7:0] otpc_crc(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    otpc_crc = c;
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  otpc_pkg::otpc_state_t state;
  otpc_pkg::otpc_fault_t fault;
  otpc_pkg::otpc_pstat_t pstat;
  logic [7:0]  page_one_status;
  logic [7:0]  page_two_status;
  logic [7:0]  fact_shadow [otpc_pkg::NUM_BLOCKS];
  logic [7:0]  cust_shadow [otpc_pkg::NUM_BLOCKS];
  logic [7:0]  corrected_block_loc;
  logic [7:0]  uncorrectable_block_loc;
  logic [3:0]  step;
  logic [1:0]  sel_page;
  logic        prog_page;
  logic [7:0]  crc_fact;
  logic [7:0]  crc_cust;
  logic [3:0]  unlock_cnt;
  logic [31:0] timer;
  logic [11:0] dec;
  logic        apb_acc;
  logic        apb_wr;
  logic        apb_rd;
  logic [7:0]  wbyte;
  logic [7:0]  next_byte;
  logic        page_busy;
  logic [7:0]  stat_word;

  assign dec     = otpc_dec(i_otp_rdata);
  assign apb_acc = i_psel && i_penable && o_pready;
  assign apb_wr  = apb_acc && i_pwrite;
  assign apb_rd  = apb_acc && !i_pwrite;
  assign wbyte   = i_pwdata[7:0];

  // Page asked for by the go byte was already tried or is badly formatted
  assign page_busy = wbyte[1]
      ? page_two_status[otpc_pkg::PS_TRY] | page_two_status[otpc_pkg::PS_FORMAT_ERROR]
      : page_one_status[otpc_pkg::PS_TRY] | page_one_status[otpc_pkg::PS_FORMAT_ERROR];

  // Status word of a finished attempt, kept in the register and blown into the fuses
  assign stat_word = (8'h1 << otpc_pkg::PS_UNDERVOLT_OK) | (8'h1 << otpc_pkg::PS_TRY) |
                     ({7'h00, !pstat.overvolt_err} << otpc_pkg::PS_OVERVOLT_OK) |
                     ({7'h00, !pstat.overvolt_err} << otpc_pkg::PS_PROGRAMMED_OK);

  // Page status words are kept in OTP at fixed addresses above the data blocks
  localparam logic [12:0] P1_STAT_ADDR = 13'h000E;
  localparam logic [12:0] P2_STAT_ADDR = 13'h000F;

  // ********************************************************
  // Load and programming sequencer
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= otpc_pkg::ST_LOAD;
      step <= 4'h0;
      sel_page <= 2'h0;
      prog_page <= 1'b0;
      timer <= 32'h0;
      o_otp_addr <= P2_STAT_ADDR;
      o_otp_we <= 1'b0;
      o_otp_wdata <= 13'h0000;
      o_load_done <= 1'b0;
      crc_fact <= 8'h00;
      crc_cust <= 8'h00;
      fault <= '0;
      page_one_status <= 8'h00;
      page_two_status <= 8'h00;
      corrected_block_loc <= 8'h00;
      uncorrectable_block_loc <= 8'h00;
      pstat.done <= 1'b0;
      pstat.program_page_err <= 1'b0;
      pstat.overvolt_err <= 1'b0;
      pstat.stab_err <= 1'b0;
      for (int b = 0; b < otpc_pkg::NUM_BLOCKS; b++) begin
        fact_shadow[b] <= otpc_pkg::HW_DEFAULT;
        cust_shadow[b] <= otpc_pkg::HW_DEFAULT;
      end
    end else begin
      o_otp_we <= 1'b0;
      if (apb_wr && i_paddr == otpc_pkg::ADDR_FAULT_CLR) begin
        fault <= fault & ~otpc_pkg::otpc_fault_t'(wbyte[6:0]);
      end
      if (state == otpc_pkg::ST_IDLE && apb_wr && i_paddr >= otpc_pkg::ADDR_CUST_SHADOW &&
          i_paddr < otpc_pkg::ADDR_CUST_SHADOW + 8'h10) begin
        cust_shadow[i_paddr[3:2]] <= wbyte;
      end
      case (state)
        otpc_pkg::ST_LOAD: begin
          // Step 0/1: page status words, 2..5 factory, 6..9 customer
          step <= step + 4'h1;
          if (step == 4'h0) begin
            page_two_status <= dec[7:0];
            o_otp_addr <= P1_STAT_ADDR;
          end else if (step == 4'h1) begin
            page_one_status <= dec[7:0];
            o_otp_addr <= 13'(otpc_pkg::FACT_BASE);
          end else begin
            if (dec[11]) begin
              fault.single_err_flag <= 1'b1;
            end
            if (dec[10]) begin
              fault.double_err_flag <= 1'b1;
            end
            if (step < 4'h6) begin
              fact_shadow[step[1:0] - 2'h2] <= dec[10] ? otpc_pkg::HW_DEFAULT : dec[7:0];
              crc_fact <= otpc_crc(crc_fact, dec[7:0]);
              if (dec[10]) begin
                fault.factory_load_err <= 1'b1;
              end
              if (step == 4'h5) begin
                if (page_two_status[otpc_pkg::PS_PROGRAMMED_OK]) begin
                  sel_page <= 2'h2;
                  page_two_status[otpc_pkg::PS_LOADED] <= 1'b1;
                  o_otp_addr <= 13'(otpc_pkg::PAGE2_BASE);
                end else if (page_one_status[otpc_pkg::PS_PROGRAMMED_OK]) begin
                  sel_page <= 2'h1;
                  page_one_status[otpc_pkg::PS_LOADED] <= 1'b1;
                  o_otp_addr <= 13'(otpc_pkg::PAGE1_BASE);
                end else begin
                  sel_page <= 2'h0;
                  o_otp_addr <= 13'(otpc_pkg::CRC_ADDR);
                  state <= otpc_pkg::ST_CRC;
                end
              end else begin
                o_otp_addr <= o_otp_addr + 13'h1;
              end
            end else begin
              cust_shadow[step[1:0] - 2'h2] <= dec[10] ? otpc_pkg::HW_DEFAULT : dec[7:0];
              crc_cust <= otpc_crc(crc_cust, dec[7:0]);
              if (dec[11]) begin
                corrected_block_loc <= {6'h00, step[1:0] - 2'h2};
                if (sel_page == 2'h2) page_two_status[otpc_pkg::PS_LOAD_WARNING] <= 1'b1;
                else page_one_status[otpc_pkg::PS_LOAD_WARNING] <= 1'b1;
              end
              if (dec[10]) begin
                fault.customer_load_err <= 1'b1;
                uncorrectable_block_loc <= {6'h00, step[1:0] - 2'h2};
                if (sel_page == 2'h2) page_two_status[otpc_pkg::PS_LOAD_ERROR] <= 1'b1;
                else page_one_status[otpc_pkg::PS_LOAD_ERROR] <= 1'b1;
              end
              o_otp_addr <= (step == 4'h9) ? 13'(otpc_pkg::CRC_ADDR) : o_otp_addr + 13'h1;
              if (step == 4'h9) state <= otpc_pkg::ST_CRC;
            end
          end
        end
        otpc_pkg::ST_CRC: begin
          // Stored word: factory CRC low nibble pair in data bits
          if (dec[7:0] != crc_fact) fault.factory_crc_err <= 1'b1;
          if (sel_page != 2'h0 && crc_cust == 8'h00) fault.customer_crc_err <= 1'b1;
          o_load_done <= 1'b1;
          state <= otpc_pkg::ST_IDLE;
        end
        otpc_pkg::ST_IDLE: begin
          if (apb_wr && i_paddr == otpc_pkg::ADDR_PROG_CTRL &&
              unlock_cnt == otpc_pkg::UNLOCK_DONE) begin
            pstat <= '{default: 1'b0, unlocked: 1'b0};
            if ((wbyte[1:0] == otpc_pkg::GO_PAGE_ONE || wbyte[1:0] == otpc_pkg::GO_PAGE_TWO) &&
                !page_busy) begin
              prog_page <= wbyte[1];
              timer <= 32'(otpc_pkg::STAB_CYCLES);
              state <= otpc_pkg::ST_STAB;
            end else begin
              pstat.program_page_err <= 1'b1;
            end
          end
        end
        otpc_pkg::ST_STAB: begin
          timer <= timer - 32'h1;
          if (i_vpp_ov || i_vpp_uv) begin
            pstat.stab_err <= 1'b1;
            state <= otpc_pkg::ST_IDLE;
          end else if (timer == 32'h1) begin
            timer <= 32'(PROG_CYCLES);
            step <= 4'h0;
            o_otp_addr <= 13'(prog_page ? otpc_pkg::PAGE2_BASE : otpc_pkg::PAGE1_BASE);
            if (prog_page) page_two_status[otpc_pkg::PS_TRY] <= 1'b1;
            else page_one_status[otpc_pkg::PS_TRY] <= 1'b1;
            state <= otpc_pkg::ST_PROG;
          end
        end
        otpc_pkg::ST_PROG: begin
          timer <= timer - 32'h1;
          if (step < 4'h4) begin
            o_otp_we <= 1'b1;
            o_otp_wdata <= otpc_enc(cust_shadow[step[1:0]]);
            o_otp_addr <= 13'(prog_page ? otpc_pkg::PAGE2_BASE : otpc_pkg::PAGE1_BASE) + 13'(step);
            step <= step + 4'h1;
          end
          if (i_vpp_ov) begin
            pstat.overvolt_err <= 1'b1;
            fault.global_overvolt_err <= 1'b1;
          end
          if (timer == 32'h1) state <= otpc_pkg::ST_STATUS;
        end
        otpc_pkg::ST_STATUS: begin
          if (prog_page) begin
            page_two_status <= stat_word | (8'h1 << otpc_pkg::PS_LOADED);
          end else begin
            page_one_status <= stat_word;
          end
          pstat.done <= !pstat.overvolt_err;
          o_otp_we <= 1'b1;
          o_otp_addr <= prog_page ? P2_STAT_ADDR : P1_STAT_ADDR;
          o_otp_wdata <= otpc_enc(stat_word);
          state <= otpc_pkg::ST_IDLE;
        end
        default: state <= otpc_pkg::ST_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Unlock sequence tracker
  // ********************************************************
  always_comb begin
    case (unlock_cnt)
      4'h0: next_byte = otpc_pkg::UNLOCK_1A;
      4'h1: next_byte = otpc_pkg::UNLOCK_1B;
      4'h2: next_byte = otpc_pkg::UNLOCK_1C;
      4'h3: next_byte = otpc_pkg::UNLOCK_1D;
      4'h4: next_byte = otpc_pkg::UNLOCK_2A;
      4'h5: next_byte = otpc_pkg::UNLOCK_2B;
      4'h6: next_byte = otpc_pkg::UNLOCK_2C;
      4'h7: next_byte = otpc_pkg::UNLOCK_2D;
      default: next_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      unlock_cnt <= 4'h0;
    end else if (apb_acc) begin
      if (unlock_cnt == otpc_pkg::UNLOCK_DONE) begin
        if (apb_wr) unlock_cnt <= 4'h0;
      end else if (apb_wr && wbyte == next_byte &&
                   i_paddr == (unlock_cnt[2] ? otpc_pkg::ADDR_UNLOCK_SECOND
                                             : otpc_pkg::ADDR_UNLOCK_FIRST) +
                              {4'h0, unlock_cnt[1:0], 2'h0}) begin
        unlock_cnt <= unlock_cnt + 4'h1;
      end else if (state == otpc_pkg::ST_IDLE) begin
        unlock_cnt <= (apb_wr && i_paddr == otpc_pkg::ADDR_UNLOCK_FIRST &&
                       wbyte == otpc_pkg::UNLOCK_1A) ? 4'h1 : 4'h0;
      end else begin
        unlock_cnt <= 4'h0;
      end
    end
  end

  // ********************************************************
  // APB slave: one wait state, then answer
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      o_cust_cfg <= 32'h0;
    end else begin
      o_cust_cfg <= {cust_shadow[3], cust_shadow[2], cust_shadow[1], cust_shadow[0]};
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      if (i_psel && i_penable && !o_pready && !i_pwrite) begin
        case (i_paddr)
          otpc_pkg::ADDR_FAULT:     o_prdata <= {25'h0, fault};
          otpc_pkg::ADDR_PAGE_ONE:  o_prdata <= {24'h0, page_one_status};
          otpc_pkg::ADDR_PAGE_TWO:  o_prdata <= {24'h0, page_two_status};
          otpc_pkg::ADDR_SEC_BLK:   o_prdata <= {24'h0, corrected_block_loc};
          otpc_pkg::ADDR_DED_BLK:   o_prdata <= {24'h0, uncorrectable_block_loc};
          otpc_pkg::ADDR_PROG_STAT: o_prdata <= {27'h0, unlock_cnt == otpc_pkg::UNLOCK_DONE,
                                                 pstat.stab_err, pstat.overvolt_err,
                                                 pstat.program_page_err, pstat.done};
          otpc_pkg::ADDR_CUST_SHADOW,
          otpc_pkg::ADDR_CUST_SHADOW + 8'h04,
          otpc_pkg::ADDR_CUST_SHADOW + 8'h08,
          otpc_pkg::ADDR_CUST_SHADOW + 8'h0C: o_prdata <= {24'h0, cust_shadow[i_paddr[3:2]]};
          default: o_pslverr <= (i_paddr < otpc_pkg::ADDR_UNLOCK_FIRST);
        endcase
      end
    end
  end

  logic unused;
  assign unused = pstat.unlocked ^ apb_rd ^ ^fact_shadow[0];
endmodule

// [verif/otpc_otp_model.sv]
// Behavioural OTP fuse array seen by the controller's memory port
`timescale 1ns/1ps
module otpc_otp_model (
  input  wire logic        i_clk_sys,
  input  wire logic [12:0] i_addr,
  input  wire logic        i_we,
  input  wire logic [12:0] i_wdata,
  output logic      [12:0] o_rdata
);
  logic [12:0] mem [16];

  initial begin
    foreach (mem[k]) begin
      mem[k] = 13'h0000;
    end
  end

  // Fuses can only be blown, never cleared
  always @(posedge i_clk_sys) begin
    if (i_we && i_addr < 13'h0010) begin
      mem[i_addr[3:0]] <= mem[i_addr[3:0]] | i_wdata;
    end
  end

  // Outside the array nothing drives: give a changing pattern
  assign o_rdata = (i_addr < 13'h0010) ? mem[i_addr[3:0]] : ~i_addr;
endmodule

// [verif/otpc_ctrl_properties.sv]
// Checker of bus timing, load and programming behaviour at the controller ports
`timescale 1ns/1ps
module otpc_ctrl_chk #(
  parameter int PROG_CYCLES = otpc_pkg::PROG_CYCLES
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic [12:0] o_otp_addr,
  input wire logic [12:0] i_otp_rdata,
  input wire logic        o_otp_we,
  input wire logic [12:0] o_otp_wdata,
  input wire logic        i_vpp_ov,
  input wire logic        i_vpp_uv,
  input wire logic [31:0] o_cust_cfg,
  input wire logic        o_load_done
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_ready_wait;
    i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");

  property p_ready_pulse;
    o_pready |-> i_psel && i_penable ##1 !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready outside one access");

  property p_slverr;
    o_pslverr |-> o_pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");

  property p_load_bound;
    $fell(i_rst) |-> ##[0:60] o_load_done;
  endproperty
  a_load_bound: assert property (p_load_bound) else $error("load not done in time");

  property p_load_hold;
    o_load_done |=> o_load_done;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("load done dropped");

  property p_no_we_loading;
    !o_load_done |-> !o_otp_we;
  endproperty
  a_no_we_loading: assert property (p_no_we_loading) else $error("write during load");

  property p_we_cust;
    o_otp_we |-> o_otp_addr >= 13'h0004;
  endproperty
  a_we_cust: assert property (p_we_cust) else $error("factory space written");

  property p_cfg_stable;
    o_load_done && $past(o_load_done) && !$past(i_psel && i_penable && i_pwrite && o_pready, 2)
      |-> $stable(o_cust_cfg);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("shadow changed unasked");

  c_prog: cover property (o_otp_we);
  c_read: cover property (o_pready && !i_pwrite);
  c_load: cover property ($rose(o_load_done));
endmodule

bind otpc_ctrl otpc_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_otp_addr(o_otp_addr),
  .i_otp_rdata(i_otp_rdata), .o_otp_we(o_otp_we), .o_otp_wdata(o_otp_wdata),
  .i_vpp_ov(i_vpp_ov), .i_vpp_uv(i_vpp_uv), .o_cust_cfg(o_cust_cfg),
  .o_load_done(o_load_done));

// [verif/otp_page_load_and_program_tb.sv]
// Self-checking bench: APB host sequences against the OTP controller
`timescale 1ns/1ps
module otp_page_load_and_program_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [12:0] otp_addr;
  logic [12:0] otp_rdata;
  logic        otp_we;
  logic [12:0] otp_wdata;
  logic        vpp_ov;
  logic        vpp_uv;
  logic [31:0] cust_cfg;
  logic        load_done;
  logic [31:0] rd;
  int          bad_count;
  int          n_checks;

  otpc_ctrl #(.PROG_CYCLES(20)) DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_otp_addr(otp_addr), .i_otp_rdata(otp_rdata), .o_otp_we(otp_we),
    .o_otp_wdata(otp_wdata), .i_vpp_ov(vpp_ov), .i_vpp_uv(vpp_uv), .o_cust_cfg(cust_cfg),
    .o_load_done(load_done));

  otpc_otp_model u_otp (
    .i_clk_sys(clk), .i_addr(otp_addr), .i_we(otp_we), .i_wdata(otp_wdata),
    .o_rdata(otp_rdata));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ********************************************************
  // Host tasks
  // ********************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Look at pready mid-cycle: the value that the next rising edge samples
    @(negedge clk);
    while (pready !== 1'h1) begin
      @(negedge clk);
    end
    rd = prdata;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic unlock(input int brk, input bit sw);
    logic [7:0] v [8];
    int         j;
    v = '{otpc_pkg::UNLOCK_1A, otpc_pkg::UNLOCK_1B, otpc_pkg::UNLOCK_1C, otpc_pkg::UNLOCK_1D,
          otpc_pkg::UNLOCK_2A, otpc_pkg::UNLOCK_2B, otpc_pkg::UNLOCK_2C, otpc_pkg::UNLOCK_2D};
    for (int i = 0; i < 8; i++) begin
      j = (sw && i < 2) ? 1 - i : i;
      if (i == brk) begin
        apb(1'h0, otpc_pkg::ADDR_FAULT, 32'h0);
      end
      apb(1'h1, otpc_pkg::ADDR_UNLOCK_FIRST + 8'(4 * j), {24'h0, v[j]});
    end
  endtask

  task automatic prog(input logic [1:0] code);
    unlock(-1, 1'b0);
    apb(1'h1, otpc_pkg::ADDR_PROG_CTRL, {30'h0, code});
    repeat (300) @(posedge clk);
  endtask

  task automatic do_reset();
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    while (load_done !== 1'h1) begin
      @(posedge clk);
    end
  endtask

  // ********************************************************
  // Test sequence
  // ********************************************************
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vpp_ov = 1'h0;
    vpp_uv = 1'h0;
    bad_count = 0;
    n_checks = 0;
    do_reset();
    rdc(otpc_pkg::ADDR_FAULT, 32'h0F, 32'h0);
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'hFF, 32'h0);
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'hFF, 32'h0);
    chk(cust_cfg, 32'h0);
    apb(1'h1, otpc_pkg::ADDR_CUST_SHADOW, 32'hA5);
    apb(1'h1, otpc_pkg::ADDR_CUST_SHADOW + 8'h04, 32'h3C);
    apb(1'h1, 8'h5C, 32'hFF);
    chk(cust_cfg, 32'h3CA5);
    unlock(2, 1'b0);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h10, 32'h0);
    unlock(-1, 1'b1);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h10, 32'h0);
    unlock(-1, 1'b0);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h10, 32'h10);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h10, 32'h10);
    apb(1'h1, otpc_pkg::ADDR_FAULT_CLR, 32'h0);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h10, 32'h0);
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'h28, 32'h0);
    prog(otpc_pkg::GO_PAGE_ONE);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h1F, 32'h01);
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'hFF, 32'hF0);
    prog(otpc_pkg::GO_PAGE_ONE);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h02, 32'h02);
    vpp_uv <= 1'h1;
    prog(otpc_pkg::GO_PAGE_TWO);
    vpp_uv <= 1'h0;
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'h20, 32'h0);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h08, 32'h08);
    do_reset();
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'h01, 32'h01);
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'h01, 32'h0);
    chk(cust_cfg, 32'h3CA5);
    apb(1'h1, otpc_pkg::ADDR_CUST_SHADOW, 32'h5A);
    apb(1'h1, otpc_pkg::ADDR_CUST_SHADOW + 8'h08, 32'h81);
    prog(otpc_pkg::GO_PAGE_TWO);
    do_reset();
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'h01, 32'h01);
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'h01, 32'h0);
    chk(cust_cfg, 32'h00813C5A);
    u_otp.mem[9] ^= 13'h0010;
    do_reset();
    rdc(otpc_pkg::ADDR_FAULT, 32'h01, 32'h01);
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'h03, 32'h03);
    chk(cust_cfg, 32'h00813C5A);
    rdc(otpc_pkg::ADDR_SEC_BLK, 32'hFF, 32'h01);
    u_otp.mem[9] ^= 13'h0010;
    u_otp.mem[10] ^= 13'h0011;
    do_reset();
    rdc(otpc_pkg::ADDR_FAULT, 32'h0A, 32'h0A);
    rdc(otpc_pkg::ADDR_PAGE_TWO, 32'h04, 32'h04);
    chk(cust_cfg, {8'h00, otpc_pkg::HW_DEFAULT, 16'h3C5A});
    rdc(otpc_pkg::ADDR_DED_BLK, 32'hFF, 32'h02);
    // Blank page one status again and break a factory word twice
    u_otp.mem[14] = 13'h0000;
    u_otp.mem[1] ^= 13'h0011;
    do_reset();
    rdc(otpc_pkg::ADDR_FAULT, 32'h04, 32'h04);
    unlock(-1, 1'b0);
    apb(1'h1, otpc_pkg::ADDR_PROG_CTRL, {30'h0, otpc_pkg::GO_PAGE_ONE});
    repeat (205) @(posedge clk);
    vpp_ov <= 1'h1;
    repeat (95) @(posedge clk);
    vpp_ov <= 1'h0;
    rdc(otpc_pkg::ADDR_FAULT, 32'h40, 32'h40);
    rdc(otpc_pkg::ADDR_PROG_STAT, 32'h05, 32'h04);
    rdc(otpc_pkg::ADDR_PAGE_ONE, 32'h70, 32'h20);
    give_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule
